/* File: tb/timer_prescale_tb_top.sv */
// Self-checking bench for the shared-prescaler timer
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module timer_prescale_tb_top;
  logic clk = 1'b0; // 50 MHz clock
  logic rst_n = 1'b0; // Async reset, active low
  logic ce = 1'b1; // Tied on: freezing via ce is not exercised
  tmr_pkg::bus_req_t req = '0; // Register port request
  logic [7:0] rdata;
  logic ext_pin = 1'b0; // External count pin
  logic sleep_active = 1'b0;
  logic wd_clr = 1'b0; // Watchdog clear instruction pulse
  logic osc_tick = 1'b0; // Watchdog oscillator tick
  logic wdt_tick_out, wdt_clear_out, timer_int_req;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0; // Cycle count for the hang limit
  int wdt_ticks = 0; // Prescaled watchdog pulses seen
  int clr_pulses = 0; // Watchdog reset pulses seen
  logic [7:0] a, b;
  int t0;

  timer_prescale timer_prescale_i (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
    .rdata(rdata), .timer_ext_count_in(ext_pin), .sleep_active(sleep_active),
    .watchdog_clear_instr(wd_clr), .wdt_osc_tick(osc_tick), .wdt_tick_out(wdt_tick_out),
    .wdt_clear_out(wdt_clear_out), .timer_int_req(timer_int_req));

  // Clock generator
  always #10 clk = ~clk;

  // Free oscillator ticks every 8 cycles, pulse counters, hang limit
  always @(posedge clk) begin
    cyc++;
    osc_tick <= (cyc % 8 == 0);
    if (wdt_tick_out === 1'b1) wdt_ticks++;
    if (wdt_clear_out === 1'b1) clr_pulses++;
    if (cyc == 20000) begin
      fails++; // Limit reached: a hang counts as a mismatch
      finish_test();
    end
  end

  // One-cycle write; ends at the edge that takes it
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    req.addr <= ad;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // One-cycle read; data sampled in the following cycle only
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    req.addr <= ad;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // One-cycle watchdog clear instruction pulse
  task automatic wdc();
    @(posedge clk);
    wd_clr <= 1'b1;
    @(posedge clk);
    wd_clr <= 1'b0;
  endtask

  // Read and compare in one call
  task automatic rdc(input logic [3:0] ad, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(ad, d);
    `CHK(nm, e, d)
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped hole
    rdc(tmr_pkg::CFG_OFS, tmr_pkg::CFG_RESET, "cfg_reset");
    rdc(tmr_pkg::CNT_OFS, 8'h00, "cnt_reset");
    rdc(tmr_pkg::CTL_OFS, 8'h00, "ctl_reset");
    wr(4'hF, 8'hAA);
    rdc(4'hF, 8'h00, "unmapped");
    // Timer mode, watchdog owns prescaler: 1:1 with write blackout
    wr(tmr_pkg::CFG_OFS, 8'h08);
    wr(tmr_pkg::CNT_OFS, 8'hFE);
    rdc(tmr_pkg::CNT_OFS, 8'hFE, "blackout");
    repeat (13) @(posedge clk);
    rdc(tmr_pkg::CNT_OFS, 8'h00, "one_to_one_wrap");
    rdc(tmr_pkg::CTL_OFS, 8'h01, "flag_set");
    `CHK("int_masked", 1'b0, timer_int_req)
    repeat (300) @(posedge clk);
    rdc(tmr_pkg::CTL_OFS, 8'h01, "flag_sticky");
    wr(tmr_pkg::CTL_OFS, 8'h03);
    repeat (2) @(posedge clk);
    `CHK("int_enabled", 1'b1, timer_int_req)
    wr(tmr_pkg::CTL_OFS, 8'h02);
    repeat (2) @(posedge clk);
    `CHK("int_cleared", 1'b0, timer_int_req)
    // Watchdog side at 1:1: one output per oscillator tick
    t0 = wdt_ticks;
    repeat (64) @(posedge clk);
    `CHK("wdt_rate", 8, wdt_ticks - t0)
    wd_clr <= 1'b1;
    @(posedge clk);
    wd_clr <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("wdt_clear", 1, clr_pulses)
    // Sleep freezes the count
    sleep_active <= 1'b1;
    rd(tmr_pkg::CNT_OFS, a);
    repeat (40) @(posedge clk);
    rdc(tmr_pkg::CNT_OFS, a, "sleep_frozen");
    sleep_active <= 1'b0;
    // Every timer-side ratio: two steps per 2^(r+2) instruction cycles each
    wdc();
    t0 = wdt_ticks;
    for (int r = 0; r < 8; r++) begin
      wr(tmr_pkg::CFG_OFS, 8'(r));
      wr(tmr_pkg::CNT_OFS, 8'h00);
      repeat (20) @(posedge clk);
      rd(tmr_pkg::CNT_OFS, a);
      repeat ((16 << r) - 2) @(posedge clk);
      rd(tmr_pkg::CNT_OFS, b);
      `CHK("rate_steps", 8'h02, 8'(b - a))
    end
    `CHK("no_wdt_when_timer", 0, wdt_ticks - t0)
    // Hand the prescaler back to the watchdog the safe way
    wdc();
    wr(tmr_pkg::CNT_OFS, 8'h00);
    wr(tmr_pkg::CFG_OFS, 8'h0F);
    wdc();
    // Pin mode, each edge choice: only the chosen edge counts
    for (int e = 0; e < 2; e++) begin
      // Pin and edge choice change at one edge: no false edge
      wr(tmr_pkg::CFG_OFS, 8'h28 | 8'(e << 4));
      ext_pin <= e[0];
      wr(tmr_pkg::CNT_OFS, 8'h00);
      repeat (12) @(posedge clk);
      ext_pin <= ~e[0];
      repeat (16) @(posedge clk);
      rdc(tmr_pkg::CNT_OFS, 8'h01, "pin_edge");
      ext_pin <= e[0];
      repeat (16) @(posedge clk);
      rdc(tmr_pkg::CNT_OFS, 8'h01, "pin_other_edge");
    end
    finish_test();
  end
endmodule

/* File: verilog/timer_prescale.sv */
// 8-bit timer/counter with a prescaler shared with the watchdog
`timescale 1ns/10ps
// Notes on behaviour
// - One prescaler, timer or watchdog, never both
// - Assign bit zero: timer; one: watchdog
// - Timer prescale ratios 1:2 through 1:256
// - Timer runs 1:1 only under watchdog assignment
// - Prescaler count never readable nor writable
// - Count write clears timer-assigned prescaler
// - Watchdog clear resets watchdog-assigned prescaler and watchdog
// - Rollover FF to 00 requests interrupt
// - Overflow flag set regardless of enable
// - Interrupt forwarded only when enabled
// - Timer frozen during sleep
// - External count sampled on Q2, Q4
// - Source bit: instruction cycle or pin
// - Edge bit picks rising or falling pin edge
// - Two instruction cycles blocked after count write
module timer_prescale (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire tmr_pkg::bus_req_t req,
  output logic [7:0] rdata,
  input wire logic timer_ext_count_in,
  input wire logic sleep_active,
  input wire logic watchdog_clear_instr,
  input wire logic wdt_osc_tick,
  output logic wdt_tick_out,
  output logic wdt_clear_out,
  output logic timer_int_req
);
  // Mask test: low n bits of the prescaler all ones
  function automatic logic low_ones(input logic [7:0] v, input logic [3:0] n);
    logic [8:0] m;
    m = (9'h001 << n) - 9'h001;
    return &(v | ~m[7:0]);
  endfunction

  // Architectural state
  tmr_pkg::cfg_t cfg_reg; // Option-style configuration
  logic [7:0] cnt_reg; // Timer count
  logic flag_reg; // Sticky overflow flag
  logic ien_reg; // Overflow interrupt enable
  logic [7:0] psc_reg; // Prescaler, not on the bus
  logic [1:0] inh_reg; // Remaining blocked instruction cycles
  tmr_pkg::phase_t q_reg; // Internal phase clock
  logic pin_prev_reg; // Previous pin level for edge detect
  logic samp2_reg; // Level caught at Q2
  logic samp4_reg; // Level caught at Q4
  logic [7:0] rdata_reg;
  logic int_reg;
  logic wdt_tick_reg;
  logic wdt_clr_reg;

  // Next values
  tmr_pkg::cfg_t cfg_next;
  logic [7:0] cnt_next;
  logic flag_next;
  logic ien_next;
  logic [7:0] psc_next;
  logic [1:0] inh_next;
  tmr_pkg::phase_t q_next;
  logic samp2_next;
  logic samp4_next;
  logic [7:0] rdata_next;

  // Decode of the register port
  wire wr_cfg = req.wr && req.addr == tmr_pkg::CFG_OFS;
  wire wr_cnt = req.wr && req.addr == tmr_pkg::CNT_OFS;
  wire wr_ctl = req.wr && req.addr == tmr_pkg::CTL_OFS;

  // Assignment and mode decode
  wire to_wdt = cfg_reg.prescaler_assign_sel;
  wire to_tmr = !to_wdt;
  wire ext_mode = cfg_reg.timer_clock_src_sel;
  wire [3:0] rate_n = {1'b0, cfg_reg.prescale_rate_field};
  wire q2 = q_reg == tmr_pkg::PH_Q2;
  wire q4 = q_reg == tmr_pkg::PH_Q4;

  // Pin level with chosen edge made rising
  wire src_lvl = timer_ext_count_in ^ cfg_reg.timer_ext_edge_sel;
  wire pin_edge = src_lvl && !pin_prev_reg;
  // Source event: instruction cycle end or pin edge
  wire src_evt = ext_mode ? pin_edge : q4;
  // Sleep stalls the timer side of the prescaler
  wire run = !sleep_active;

  // Timer-side prescaler tick and wrap test
  wire psc_tmr_evt = to_tmr && run && src_evt;
  wire psc_tmr_wrap = low_ones(psc_reg, rate_n + 4'h1);
  // Watchdog-side prescaler event and output
  wire psc_wdt_evt = to_wdt && wdt_osc_tick;
  wire wdt_tick_w = psc_wdt_evt && low_ones(psc_reg, rate_n);

  // Level whose rising edge steps the counter in pin mode
  wire div_lvl = to_tmr ? psc_reg[cfg_reg.prescale_rate_field] : src_lvl;
  // Increment from the internal clock path
  wire inc_int = !ext_mode && src_evt && (to_wdt || psc_tmr_wrap);
  // Increment from the Q2/Q4 synchroniser
  wire inc_ext = ext_mode && q4 && samp2_reg && !samp4_reg;
  // Blocked after a count write or while asleep
  wire inc = run && inh_reg == 2'h0 && (inc_int || inc_ext);
  wire roll = inc && cnt_reg == tmr_pkg::CNT_MAX;

  // Phase advance, four phases per instruction
  always_comb begin
    unique case (q_reg)
      tmr_pkg::PH_Q1: q_next = tmr_pkg::PH_Q2;
      tmr_pkg::PH_Q2: q_next = tmr_pkg::PH_Q3;
      tmr_pkg::PH_Q3: q_next = tmr_pkg::PH_Q4;
      tmr_pkg::PH_Q4: q_next = tmr_pkg::PH_Q1;
    endcase
  end

  // Sampling of the divided level on Q2 then Q4
  assign samp2_next = q2 ? div_lvl : samp2_reg;
  assign samp4_next = q4 ? samp2_reg : samp4_reg;

  // Configuration and enable follow software writes
  assign cfg_next = wr_cfg ? tmr_pkg::cfg_t'(req.wdata) : cfg_reg;
  assign ien_next = wr_ctl ? req.wdata[tmr_pkg::IEN_POS] : ien_reg;

  // Count: software write wins over an increment
  assign cnt_next = wr_cnt ? req.wdata : (inc ? cnt_reg + 8'h01 : cnt_reg);

  // Flag: hardware set wins over a software clear
  assign flag_next = roll || (wr_ctl ? req.wdata[tmr_pkg::FLAG_POS] : flag_reg);

  // Prescaler clears; no bus path reaches it
  always_comb begin
    if (wr_cnt && to_tmr) begin
      psc_next = tmr_pkg::PSC_RESET;
    end else if (watchdog_clear_instr && to_wdt) begin
      psc_next = tmr_pkg::PSC_RESET;
    end else if (psc_tmr_evt || psc_wdt_evt) begin
      psc_next = psc_reg + 8'h01;
    end else begin
      psc_next = psc_reg;
    end
  end

  // Blackout counter, counted down at each instruction end
  always_comb begin
    if (wr_cnt) begin
      inh_next = tmr_pkg::INHIBIT_CYC;
    end else if (q4 && inh_reg != 2'h0) begin
      inh_next = inh_reg - 2'h1;
    end else begin
      inh_next = inh_reg;
    end
  end

  // Read mux; the prescaler has no address
  always_comb begin
    rdata_next = tmr_pkg::RD_NONE;
    if (req.rd) begin
      unique case (req.addr)
        tmr_pkg::CFG_OFS: rdata_next = cfg_reg;
        tmr_pkg::CNT_OFS: rdata_next = cnt_reg;
        tmr_pkg::CTL_OFS: rdata_next = {6'h00, ien_reg, flag_reg};
        default: rdata_next = tmr_pkg::RD_NONE;
      endcase
    end
  end

  // Timer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= tmr_pkg::cfg_t'(tmr_pkg::CFG_RESET);
      cnt_reg <= tmr_pkg::CNT_RESET;
      flag_reg <= 1'b0;
      ien_reg <= 1'b0;
      psc_reg <= tmr_pkg::PSC_RESET;
      inh_reg <= 2'h0;
    end else if (ce) begin
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      psc_reg <= psc_next;
      inh_reg <= inh_next;
    end
  end

  // Phase and synchroniser state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= tmr_pkg::PH_Q1;
      pin_prev_reg <= 1'b0;
      samp2_reg <= 1'b0;
      samp4_reg <= 1'b0;
    end else if (ce) begin
      q_reg <= q_next;
      pin_prev_reg <= src_lvl;
      samp2_reg <= samp2_next;
      samp4_reg <= samp4_next;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= tmr_pkg::RD_NONE;
      int_reg <= 1'b0;
      wdt_tick_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
    end else if (ce) begin
      rdata_reg <= rdata_next;
      int_reg <= flag_next && ien_next;
      wdt_tick_reg <= wdt_tick_w;
      wdt_clr_reg <= watchdog_clear_instr;
    end
  end

  assign rdata = rdata_reg;
  assign timer_int_req = int_reg;
  assign wdt_tick_out = wdt_tick_reg;
  assign wdt_clear_out = wdt_clr_reg;

  // Count write with the clock running
  sequence cnt_write_s;
    ce && wr_cnt;
  endsequence

  // Overflow sets the flag and wraps to zero
  property roll_p;
    @(posedge clk) disable iff (!rst_n)
      ce && roll && !wr_cnt |=> flag_reg && cnt_reg == 8'h00;
  endproperty
  roll_flag_a: assert property (roll_p) else $error("rollover lost");

  // Flag stays set with no software write
  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    flag_reg && !wr_ctl |=> flag_reg) else $error("flag cleared by hardware");

  // Interrupt line follows flag and enable
  int_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> timer_int_req == (flag_reg && ien_reg))
    else $error("interrupt gating wrong");

  // Count write clears the timer prescaler
  psc_clr_tmr_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_write_s and to_tmr |=> psc_reg == 8'h00) else $error("prescaler not cleared");

  // Watchdog clear resets watchdog-assigned prescaler and pulses out
  wdt_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && watchdog_clear_instr && to_wdt && !wr_cnt |=> psc_reg == 8'h00 && wdt_clear_out)
    else $error("watchdog clear missed");

  // Two instruction cycles of no increment after a write
  property inhibit_p;
    @(posedge clk) disable iff (!rst_n)
      cnt_write_s ##1 (ce && !wr_cnt) |=> $stable(cnt_reg);
  endproperty
  inh_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    inh_reg != 2'h0 |-> !inc) else $error("increment during blackout");
  inh_load_a: assert property (inhibit_p) else $error("count moved after write");

  // Sleep freezes the count
  sleep_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_active && !wr_cnt |=> $stable(cnt_reg)) else $error("count moved in sleep");

  // Watchdog-assigned timer steps every instruction
  one_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    to_wdt && !ext_mode && q4 && run && inh_reg == 2'h0 |-> inc)
    else $error("1:1 step missing");

  // Timer-assigned prescaler ignores watchdog ticks
  exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
    to_tmr |-> !wdt_tick_w) else $error("prescaler shared");

  // Pin mode only steps at Q4
  ext_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    ext_mode && inc |-> q4) else $error("pin step off phase");
endmodule

/* File: verilog/tmr_pkg.sv */
// Shared constants and types for the 8-bit timer with shared prescaler
package tmr_pkg;
  // Register word offsets
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] CNT_OFS = 4'h1;
  localparam logic [3:0] CTL_OFS = 4'h2;
  // Control word field positions
  localparam int FLAG_POS = 0;
  localparam int IEN_POS = 1;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h3F;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Instruction cycles of increment blackout after a count write
  localparam logic [1:0] INHIBIT_CYC = 2'h2;
  // Clock phases within one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
  // Configuration word: clock source, edge, assignment, rate
  typedef struct packed {
    logic [1:0] spare;
    logic timer_clock_src_sel;
    logic timer_ext_edge_sel;
    logic prescaler_assign_sel;
    logic [2:0] prescale_rate_field;
  } cfg_t;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage
